// >>> hdl/obc_pkg.sv
package obc_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_OPT0   = 8'h00;
  localparam logic [7:0] OFF_OPT1   = 8'h04;
  localparam logic [7:0] OFF_CMD    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // Blank non-volatile content
  localparam logic [7:0] BLANK_BYTE = 8'hff;

  // Option byte 0 field positions
  localparam int B0_HALT_RST = 7;
  localparam int B0_WDOG_SW  = 6;
  localparam int B0_VD_HI    = 4;
  localparam int B0_VD_LO    = 3;
  localparam int B0_LOCK_N   = 0;

  // Option byte 1 field positions
  localparam int B1_PKG      = 7;
  localparam int B1_RESET_DELAY_SELECT     = 6;
  localparam int B1_OSC_HI   = 5;
  localparam int B1_OSC_LO   = 4;
  localparam int B1_RNG_HI   = 3;
  localparam int B1_RNG_LO   = 1;
  localparam int B1_DBL_N    = 0;

  // Command register bit
  localparam int CMD_ERASE   = 0;

  // Voltage detector settings
  localparam logic [1:0] VD_HIGH = 2'h0;
  localparam logic [1:0] VD_MED  = 2'h1;
  localparam logic [1:0] VD_LOW  = 2'h2;
  localparam logic [1:0] VD_OFF  = 2'h3;

  // Clock source codes
  localparam logic [1:0] OSC_RESONATOR = 2'h0;
  localparam logic [1:0] OSC_RESERVED  = 2'h1;
  localparam logic [1:0] OSC_INT_RC    = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL  = 2'h3;

  // Resonator range codes
  localparam logic [2:0] RANGE_LOW_POWER    = 3'h0;
  localparam logic [2:0] RANGE_MEDIUM_POWER = 3'h1;
  localparam logic [2:0] RANGE_MEDIUM_SPEED = 3'h2;
  localparam logic [2:0] RANGE_HIGH_SPEED   = 3'h3;

  // Reset phase lengths in CPU cycles
  localparam int DELAY_LONG_CYC  = 4096;
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_CNT_W     = 13;

  // Option erase sequencer, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WIPE_USER = 2'b01,
    ST_WIPE_OPT  = 2'b11
  } obc_wipe_t;

endpackage

// >>> hdl/obc_option_decoder.sv
// Summary of operation
// R1 - Option bytes reachable only in programming mode
// R2 - Blank option bytes read as all ones
// R3 - Halt bit set: reset on halt entry; here only while the watchdog is active
// R4 - Watchdog bit clear: watchdog always enabled
// R5 - Two-bit field sets detector threshold or off
// R6 - Programmer keeps reserved bits at defaults
// R7 - Lock bit clear: protection, flash writes blocked
// R8 - Locked option erase wipes user memory first
// R9 - Delay bit selects 4096 or 256 cycles
// R10 - Resonator users should choose 4096-cycle delay
// R11 - Two-bit field selects main clock source
// R12 - Three-bit field selects resonator drive range
// R13 - External clock forces medium-power range
// R14 - Doubler bit clear enables frequency doubler
// R15 - No doubler with internal RC oscillator
// R16 - Doubler only with medium-power range
// R17 - Package bit selects 44-pin or 32-pin
// R18 - Unbonded pads held as pulled-up inputs
// R19 - ROM variant options are hard-wired
// R20 - Options sampled at reset, held until next
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
module obc_option_decoder #(
  parameter bit                     ROM_VARIANT = 1'b0,
  parameter logic [7:0]             ROM_BYTE0   = 8'hff,
  parameter logic [7:0]             ROM_BYTE1   = 8'hff,
  parameter int                     LONG_DELAY  = obc_pkg::DELAY_LONG_CYC,
  parameter int                     SHORT_DELAY = obc_pkg::DELAY_SHORT_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Mode and system events
  input  wire logic                 progMode,
  input  wire logic                 wdogSwEnable,
  input  wire logic                 haltEntry,
  input  wire logic                 haltExit,
  input  wire logic                 userEraseDone,
  output logic                      userEraseReq,
  // Decoded configuration
  output logic                      wdogResetOnStop,
  output logic                      wdogTypeSelect,
  output logic                      wdogHwEnable,
  output logic                      haltResetReq,
  output logic [1:0]                voltageDetectLevel,
  output logic                      lowVoltageReset,
  output logic                      supplyWarningDetect,
  output logic                      readoutLock,
  output logic                      flashWriteBlock,
  output logic                      resetDelaySelect,
  output logic [1:0]                oscSourceSelect,
  output logic [2:0]                resonatorRange,
  output logic                      doublerEnable,
  output logic                      packagePinSelect,
  output logic                      unbondedPullup,
  // Reset sequencing
  output logic                      cpuResetHold,
  output logic                      haltWakeHold
);
  import obc_pkg::*;

  // Non-volatile option storage, blank at power-up
  logic [7:0]             nvByte0_q = BLANK_BYTE;
  logic [7:0]             nvByte1_q = BLANK_BYTE;
  obc_wipe_t              wipe_q;
  obc_wipe_t              wipe_d;
  logic                   eraseReq_q;
  logic [DELAY_CNT_W-1:0] delayCnt_q;
  logic                   prReady_q;
  logic                   prErr_q;
  logic [31:0]            prData_q;

  // Registered configuration outputs
  logic                   haltRst_q;
  logic                   wdogSw_q;
  logic                   wdogHw_q;
  logic                   haltReq_q;
  logic [1:0]             vdLevel_q;
  logic                   vdOn_q;
  logic                   lockOn_q;
  logic                   rstShort_q;
  logic [1:0]             oscSel_q;
  logic [2:0]             range_q;
  logic                   dblOn_q;
  logic                   pkg44_q;
  logic                   cpuHold_q;
  logic                   wakeHold_q;
  logic                   pullup_q;

  // R19 mask variants - options come from fixed code, storage unused
  wire logic [7:0] optByte0 = ROM_VARIANT ? ROM_BYTE0 : nvByte0_q;
  wire logic [7:0] optByte1 = ROM_VARIANT ? ROM_BYTE1 : nvByte1_q;
  wire logic       optLocked = ~optByte0[B0_LOCK_N];

  // Decode of stored bytes, sampled only under reset
  wire logic [1:0] vdField  = optByte0[B0_VD_HI:B0_VD_LO];
  wire logic [1:0] oscField = optByte1[B1_OSC_HI:B1_OSC_LO];
  // R13 external source - range forced to medium power
  wire logic [2:0] rngField = (oscField == OSC_EXTERNAL) ? RANGE_MEDIUM_POWER
                                                         : optByte1[B1_RNG_HI:B1_RNG_LO];

  // APB phase and address decode
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & prReady_q;
  wire logic hitOpt0    = (paddr == OFF_OPT0);
  wire logic hitOpt1    = (paddr == OFF_OPT1);
  wire logic hitCmd     = (paddr == OFF_CMD);
  wire logic hitStatus  = (paddr == OFF_STATUS);
  wire logic hitOption  = hitOpt0 | hitOpt1 | hitCmd;
  wire logic wipeBusy   = (wipe_q != ST_IDLE);

  // R1 option space refused outside programming mode
  wire logic errMode    = hitOption & ~progMode;
  // R7 locked bytes cannot be rewritten, only erased
  wire logic errLock    = pwrite & (hitOpt0 | hitOpt1) & optLocked;
  wire logic errFixed   = pwrite & hitOption & (ROM_VARIANT | wipeBusy);
  wire logic errAccess  = errMode | errLock | errFixed | (pwrite & hitStatus)
                          | ~(hitOption | hitStatus);
  wire logic commitWr   = accessDone & pwrite & ~prErr_q;
  wire logic wrOpt0     = commitWr & hitOpt0 & pstrb[0];
  wire logic wrOpt1     = commitWr & hitOpt1 & pstrb[0];
  wire logic eraseCmd   = commitWr & hitCmd & pstrb[0] & pwdata[CMD_ERASE];

  // Status word of latched settings and live state
  wire logic [31:0] statusWord = {16'h0000, progMode, wipeBusy, cpuHold_q, pkg44_q,
                                  dblOn_q, range_q, oscSel_q, rstShort_q, lockOn_q,
                                  vdLevel_q, wdogSw_q, haltRst_q};
  // R2 read of blank storage returns all ones
  wire logic [31:0] readMux = hitOpt0   ? {24'h000000, optByte0} :
                              hitOpt1   ? {24'h000000, optByte1} :
                              hitStatus ? statusWord : 32'h00000000;

  // APB answer, one wait-free access cycle after setup
  always_ff @(posedge clk) begin
    if (reset) begin
      prReady_q <= 1'b0;
      prErr_q   <= 1'b0;
      prData_q  <= 32'h00000000;
    end else begin
      prReady_q <= setupPhase;
      prErr_q   <= setupPhase & errAccess;
      prData_q  <= (setupPhase & ~pwrite & ~errAccess) ? readMux : 32'h00000000;
    end
  end

  // R8 erase sequencer: user memory wiped before locked options
  always_comb begin
    wipe_d = wipe_q;
    unique case (wipe_q)
      ST_IDLE: begin
        if (eraseCmd) begin
          wipe_d = optLocked ? ST_WIPE_USER : ST_WIPE_OPT;
        end
      end
      ST_WIPE_USER: begin
        if (userEraseDone) begin
          wipe_d = ST_WIPE_OPT;
        end
      end
      ST_WIPE_OPT: begin
        wipe_d = ST_IDLE;
      end
      default: begin
        wipe_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and user-memory erase request
  always_ff @(posedge clk) begin
    if (reset) begin
      wipe_q     <= ST_IDLE;
      eraseReq_q <= 1'b0;
    end else begin
      wipe_q     <= wipe_d;
      eraseReq_q <= (wipe_d == ST_WIPE_USER);
    end
  end

  // R2 erase leaves blank bytes; writes store programmed values
  always_ff @(posedge clk) begin
    if (wipe_q == ST_WIPE_OPT) begin
      nvByte0_q <= BLANK_BYTE;
      nvByte1_q <= BLANK_BYTE;
    end else begin
      if (wrOpt0) begin
        nvByte0_q <= pwdata[7:0];
      end
      if (wrOpt1) begin
        nvByte1_q <= pwdata[7:0];
      end
    end
  end

  // R20 configuration captured while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      haltRst_q  <= optByte0[B0_HALT_RST];
      wdogSw_q   <= optByte0[B0_WDOG_SW];
      // R4 hardware watchdog type
      wdogHw_q   <= ~optByte0[B0_WDOG_SW];
      // R5 detector threshold or off
      vdLevel_q  <= vdField;
      vdOn_q     <= (vdField != VD_OFF);
      // R7 protection enable
      lockOn_q   <= ~optByte0[B0_LOCK_N];
      rstShort_q <= optByte1[B1_RESET_DELAY_SELECT];
      // R11 R12 clock source and range
      oscSel_q   <= oscField;
      range_q    <= rngField;
      // R14 doubler enable
      dblOn_q    <= ~optByte1[B1_DBL_N];
      // R17 package selection
      pkg44_q    <= optByte1[B1_PKG];
      // R18 unbonded pads pulled up
      pullup_q   <= ~optByte1[B1_PKG];
    end
  end

  // R3 halt entry with active watchdog requests reset
  always_ff @(posedge clk) begin
    if (reset) begin
      haltReq_q <= 1'b0;
    end else begin
      haltReq_q <= haltEntry & haltRst_q & (wdogHw_q | wdogSwEnable);
    end
  end

  // R9 reset phase and halt wake delay length
  wire logic [DELAY_CNT_W-1:0] delayLast = rstShort_q ? DELAY_CNT_W'(SHORT_DELAY - 1)
                                                      : DELAY_CNT_W'(LONG_DELAY - 1);
  wire logic delayRun  = cpuHold_q | wakeHold_q;
  wire logic delayEnd  = delayRun & (delayCnt_q == delayLast);

  always_ff @(posedge clk) begin
    if (reset) begin
      delayCnt_q <= '0;
      cpuHold_q  <= 1'b1;
      wakeHold_q <= 1'b0;
    end else begin
      if (delayEnd) begin
        delayCnt_q <= '0;
        cpuHold_q  <= 1'b0;
        wakeHold_q <= 1'b0;
      end else if (delayRun) begin
        delayCnt_q <= delayCnt_q + 1'b1;
      end else if (haltExit) begin
        delayCnt_q <= '0;
        wakeHold_q <= 1'b1;
      end
    end
  end

  // Output wiring, all from flip-flops
  assign prdata              = prData_q;
  assign pready              = prReady_q;
  assign pslverr             = prErr_q;
  assign userEraseReq        = eraseReq_q;
  assign wdogResetOnStop     = haltRst_q;
  assign wdogTypeSelect      = wdogSw_q;
  assign wdogHwEnable        = wdogHw_q;
  assign haltResetReq        = haltReq_q;
  assign voltageDetectLevel  = vdLevel_q;
  assign lowVoltageReset     = vdOn_q;
  assign supplyWarningDetect = vdOn_q;
  assign readoutLock         = lockOn_q;
  // R7 protection also blocks flash writes
  assign flashWriteBlock     = lockOn_q;
  assign resetDelaySelect    = rstShort_q;
  assign oscSourceSelect     = oscSel_q;
  assign resonatorRange      = range_q;
  assign doublerEnable       = dblOn_q;
  assign packagePinSelect    = pkg44_q;
  // Pull-up flag has its own flop, so the pin needs no inverter
  assign unbondedPullup      = pullup_q;
  assign cpuResetHold        = cpuHold_q;
  assign haltWakeHold        = wakeHold_q;

  // Checks on the decoded behaviour
  a_halt_reset_on: assert property (@(posedge clk) disable iff (reset) // R3
    haltEntry && haltRst_q && wdogHw_q |=> haltReq_q)
    else $error("halt entry did not raise reset request");

  a_halt_reset_off: assert property (@(posedge clk) disable iff (reset) // R3
    !haltRst_q |=> !haltReq_q)
    else $error("halt reset request while option is clear");

  a_wdog_hw_type: assert property (@(posedge clk) // R4
    reset |=> wdogHw_q == !$past(optByte0[B0_WDOG_SW]))
    else $error("watchdog type not taken from option byte");

  a_detect_off: assert property (@(posedge clk) // R5
    reset && vdField == VD_OFF |=> !lowVoltageReset && !supplyWarningDetect)
    else $error("voltage detectors enabled with off code");

  a_prog_mode_only: assert property (@(posedge clk) disable iff (reset) // R1
    setupPhase && hitOption && !progMode |=> pslverr && pready)
    else $error("option access outside programming mode not refused");

  a_lock_no_write: assert property (@(posedge clk) disable iff (reset) // R7
    setupPhase && pwrite && hitOpt0 && optLocked |=> ##1 $stable(nvByte0_q))
    else $error("locked option byte was rewritten");

  a_user_wipe_first: assert property (@(posedge clk) disable iff (reset) // R8
    eraseCmd && optLocked |=> userEraseReq && nvByte0_q == $past(nvByte0_q))
    else $error("locked erase skipped user memory wipe");

  a_blank_after_wipe: assert property (@(posedge clk) disable iff (reset) // R2
    wipe_q == ST_WIPE_OPT |=> nvByte0_q == BLANK_BYTE && nvByte1_q == BLANK_BYTE)
    else $error("erased option bytes not blank");

  a_ext_range_mp: assert property (@(posedge clk) disable iff (reset) // R13
    oscSel_q == OSC_EXTERNAL |-> range_q == RANGE_MEDIUM_POWER)
    else $error("external clock without medium power range");

  a_cfg_held: assert property (@(posedge clk) disable iff (reset) // R20
    !$past(reset) |-> $stable({haltRst_q, vdLevel_q, lockOn_q, oscSel_q, range_q, dblOn_q}))
    else $error("configuration changed outside reset");

  a_reset_release: assert property (@(posedge clk) disable iff (reset) // R9
    $fell(cpuResetHold) |-> $past(delayCnt_q) == delayLast)
    else $error("reset phase length wrong");

  a_wake_release: assert property (@(posedge clk) disable iff (reset) // R9
    $fell(haltWakeHold) |-> $past(delayCnt_q) == delayLast)
    else $error("halt wake delay length wrong");

  a_lock_taken: assert property (@(posedge clk) // R7
    reset |=> readoutLock == !$past(optByte0[B0_LOCK_N]) && flashWriteBlock == readoutLock)
    else $error("protection not taken from option byte");

  a_doubler_taken: assert property (@(posedge clk) // R14
    reset |=> doublerEnable == !$past(optByte1[B1_DBL_N]))
    else $error("doubler enable not taken from option byte");

  a_pkg_taken: assert property (@(posedge clk) // R17
    reset |=> packagePinSelect == $past(optByte1[B1_PKG]) && unbondedPullup == !packagePinSelect)
    else $error("package selection not taken from option byte");

  a_busy_refused: assert property (@(posedge clk) disable iff (reset) // R8
    setupPhase && pwrite && hitOption && wipeBusy |=> pslverr && pready)
    else $error("option write accepted during erase");

endmodule

// >>> tb/obc_prog_tool.sv
`timescale 1ns/1ns
module obc_prog_tool (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  import obc_pkg::*;

  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end

  // One transfer, entered just after a rising edge; held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask

  // Writes byte 1 first so that a locking byte 0 lands last
  task automatic prog_options(input logic [7:0] b0, input logic [7:0] b1, output logic e);
    logic [31:0] q;
    logic        e0;
    logic        e1;
    b0 = b0 | 8'h26;
    if (b1[5:4] == OSC_RESONATOR) b1[6] = 1'b0;
    if (b1[5:4] == OSC_INT_RC || b1[3:1] != RANGE_MEDIUM_POWER) b1[0] = 1'b1;
    xfer(1'b1, OFF_OPT1, {24'h0, b1}, q, e1);
    xfer(1'b1, OFF_OPT0, {24'h0, b0}, q, e0);
    e = e0 | e1;
  endtask
endmodule

// >>> tb/option_byte_config_decoder_test.sv
`timescale 1ns/1ns
module option_byte_config_decoder_test;
  import obc_pkg::*;
  localparam int LONG_N  = 16;
  localparam int SHORT_N = 4;
  // Stimulus and observed signals
  logic        clk, reset, progMode, wdogSwEnable, haltEntry, haltExit, userEraseDone;
  logic        psel, penable, pwrite, pready, pslverr, userEraseReq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [1:0]  voltageDetectLevel, oscSourceSelect;
  logic [2:0]  resonatorRange;
  logic        wdogResetOnStop, wdogTypeSelect, wdogHwEnable, haltResetReq, lowVoltageReset;
  logic        supplyWarningDetect, readoutLock, flashWriteBlock, resetDelaySelect;
  logic        doublerEnable, packagePinSelect, unbondedPullup, cpuResetHold, haltWakeHold;
  int          miscompares = 0, checks = 0, cnt;
  // Rows: option byte 0, option byte 1, expected decoded settings
  logic [33:0] rows [7] = '{{8'h27, 8'h01, 18'h09801}, {8'haf, 8'h82, 18'h2b80e},
    {8'h77, 8'h65, 18'h15991}, {8'hff, 8'h87, 18'h3601a}, {8'ha7, 8'h71, 18'h299c9},
    {8'h2f, 8'h13, 18'h0b849}, {8'hfe, 8'hff, 18'h367ca}};
  wire  [17:0] cfg = {wdogResetOnStop, wdogTypeSelect, wdogHwEnable, voltageDetectLevel,
    lowVoltageReset, supplyWarningDetect, readoutLock, flashWriteBlock, resetDelaySelect,
    oscSourceSelect, resonatorRange, doublerEnable, packagePinSelect, unbondedPullup};

  // Clock
  always #2 clk = ~clk;

  obc_option_decoder #(.LONG_DELAY(LONG_N), .SHORT_DELAY(SHORT_N)) obc_option_decoder_inst (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .progMode, .wdogSwEnable, .haltEntry, .haltExit, .userEraseDone, .userEraseReq,
    .wdogResetOnStop, .wdogTypeSelect, .wdogHwEnable, .haltResetReq, .voltageDetectLevel,
    .lowVoltageReset, .supplyWarningDetect, .readoutLock, .flashWriteBlock, .resetDelaySelect,
    .oscSourceSelect, .resonatorRange, .doublerEnable, .packagePinSelect, .unbondedPullup,
    .cpuResetHold, .haltWakeHold);
  obc_prog_tool obc_prog_tool_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr);

  // Comparisons
  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic x, input logic g);
    chk_word(n, {31'h0, x}, {31'h0, g});
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Bus access; for reads d is the expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic xe, input string n);
    @(posedge clk);
    obc_prog_tool_inst.xfer(w, a, d, q, e);
    chk_bit({n, " err"}, xe, e);
    if (!w) chk_word(n, d, q);
  endtask

  // Length of a hold output, counted in whole cycles
  task automatic hold_len(input logic w, input int n, input string s);
    cnt = 0;
    repeat (40) begin
      @(negedge clk);
      if ((w ? haltWakeHold : cpuResetHold) === 1'b1) cnt++;
    end
    chk_bit(s, 1'b1, cnt == n);
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    progMode = 1'b0;
    wdogSwEnable = 1'b0;
    haltEntry = 1'b0;
    haltExit = 1'b0;
    userEraseDone = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    hold_len(1'b0, SHORT_N, "blank delay");
    chk_word("blank cfg", 32'h361ca, {14'h0, cfg});
    acc(1'b0, OFF_OPT0, 32'h0, 1'b1, "opt0 closed");
    progMode <= 1'b1;
    acc(1'b0, OFF_OPT0, 32'hff, 1'b0, "opt0 blank");
    acc(1'b0, OFF_OPT1, 32'hff, 1'b0, "opt1 blank");
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      obc_prog_tool_inst.prog_options(rows[i][33:26], rows[i][25:18], e);
      chk_bit("prog err", 1'b0, e);
      acc(1'b0, OFF_OPT1, {24'h0, rows[i][25:18]}, 1'b0, "opt1 back");
      do_reset;
      hold_len(1'b0, rows[i][24] ? SHORT_N : LONG_N, "reset delay");
      chk_word("cfg", {14'h0, rows[i][17:0]}, {14'h0, cfg});
      @(posedge clk);
      haltEntry <= 1'b1;
      wdogSwEnable <= i[0];
      @(posedge clk);
      haltEntry <= 1'b0;
      @(negedge clk);
      chk_bit("halt reset", rows[i][33] & (~rows[i][32] | i[0]), haltResetReq);
      @(negedge clk);
      chk_bit("halt pulse end", 1'b0, haltResetReq);
      @(posedge clk);
      haltExit <= 1'b1;
      @(posedge clk);
      haltExit <= 1'b0;
      hold_len(1'b1, rows[i][24] ? SHORT_N : LONG_N, "wake delay");
    end
    // Locked bytes: writes refused, erase wipes user memory first
    acc(1'b1, OFF_OPT0, 32'hff, 1'b1, "locked write");
    acc(1'b1, OFF_CMD, 32'h1, 1'b0, "erase cmd");
    @(negedge clk);
    chk_bit("user wipe req", 1'b1, userEraseReq);
    acc(1'b0, OFF_OPT0, 32'hfe, 1'b0, "opt0 kept");
    acc(1'b1, OFF_OPT1, 32'h0, 1'b1, "busy write");
    @(posedge clk);
    userEraseDone <= 1'b1;
    @(posedge clk);
    userEraseDone <= 1'b0;
    repeat (3) @(negedge clk);
    chk_bit("user wipe done", 1'b0, userEraseReq);
    acc(1'b0, OFF_OPT0, 32'hff, 1'b0, "opt0 erased");
    // Open erase; decoded settings stay until the next reset
    acc(1'b1, OFF_OPT0, 32'h27, 1'b0, "opt0 write");
    acc(1'b1, OFF_CMD, 32'h1, 1'b0, "erase open");
    repeat (2) @(posedge clk);
    acc(1'b0, OFF_OPT0, 32'hff, 1'b0, "opt0 blank again");
    chk_word("cfg held", 32'h367ca, {14'h0, cfg});
    acc(1'b0, OFF_STATUS, 32'h91ff, 1'b0, "status");
    acc(1'b0, 8'h10, 32'h0, 1'b1, "unmapped");
    acc(1'b1, OFF_STATUS, 32'h0, 1'b1, "status write");
    progMode <= 1'b0;
    acc(1'b1, OFF_OPT1, 32'h0, 1'b1, "opt1 closed");
    tally_and_finish;
  end
endmodule
